// file: hdl/panel_map.svh
// Constants for the front-panel option and error display block.
`ifndef PANEL_MAP_SVH
`define PANEL_MAP_SVH
// ****************************************************************
// Register offsets
// ****************************************************************
`define REG_CTRL 5'h00
`define REG_ERROR 5'h04
`define REG_STATUS 5'h08
`define REG_OPTION 5'h0c
`define REG_PANEL 5'h10
// ****************************************************************
// Panel patterns and codes
// ****************************************************************
`define SW_ZERO 8'h00
`define DISP_IDLE 8'hff
`define SW_SHOW_OPT 8'hdd
`define SW_CHECK 8'hcc
`define SW_ENTER 8'hee
`define SW_PRE_LO 4'ha
`define SW_PRE_HI 4'hb
`define ERR_NONE 8'h00
`define ERR_OUT_ABORT 8'h06
`define ERR_FILLING 8'h0f
`define OPT_RESET 8'h00
`define NIB_RESET 4'h0
// ****************************************************************
// Option byte bits
// ****************************************************************
`define OPT_NO_OUT 0
`define OPT_NO_IN 1
`define OPT_TERM 2
`define OPT_INVERT 4
`define OPT_SELFTEST 5
`define OPT_NO_MODEM 6
`define OPT_MAINT 7
// ****************************************************************
// Timing and AXI response codes
// ****************************************************************
`define PHASE_CYCLES 4'h8
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10
`endif

// file: hdl/panel_pkg.sv
// Types shared by the front-panel display block.
package panel_pkg;
    typedef enum logic [1:0] {
        PH_READ = 2'b01,
        PH_WRITE = 2'b10
    } phase_t;
    typedef struct packed {
        logic valid;
        logic [7:0] code;
    } err_msg_t;
endpackage

// file: hdl/panel_mux.sv
// Switch/display sharing of the panel data lines.
`timescale 1ns/10ps
`include "panel_map.svh"
module panel_mux #(
    parameter int PHASE = 8
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Panel lines.
    input wire logic [7:0] panel_data_i,
    output logic [7:0] panel_data_o,
    output logic panel_data_oe,
    output logic panel_select_control,
    // Block side.
    input wire logic [7:0] show,
    output logic [7:0] sw,
    output logic sw_valid
);
    initial begin
        if (PHASE < 4) begin
            $error("PHASE too short");
        end
    end
    logic [7:0] s1_q;
    logic [7:0] s2_q;
    logic [7:0] cnt_q;
    logic [1:0] vpipe_q;
    panel_pkg::phase_t ph_q;
    // ****************************************************************
    // Phase sequencer
    // ****************************************************************
    // The switch word leaves the synchroniser two edges after the last read-phase
    // sample; taking it any later would catch display data instead.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 8'h00;
            ph_q <= panel_pkg::PH_READ;
        end else if (cnt_q == 8'(PHASE - 1)) begin
            cnt_q <= 8'h00;
            case (ph_q)
                panel_pkg::PH_READ: ph_q <= panel_pkg::PH_WRITE;
                panel_pkg::PH_WRITE: ph_q <= panel_pkg::PH_READ;
                default: ph_q <= panel_pkg::PH_READ;
            endcase
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q <= 8'h00;
            s2_q <= 8'h00;
            vpipe_q <= 2'b00;
            sw <= `SW_ZERO;
            sw_valid <= 1'b0;
            panel_data_o <= `DISP_IDLE;
        end else begin
            s1_q <= panel_data_i;
            s2_q <= s1_q;
            vpipe_q <= {vpipe_q[0], ph_q == panel_pkg::PH_READ && cnt_q == 8'(PHASE - 1)};
            sw_valid <= vpipe_q[1];
            if (vpipe_q[1]) begin
                sw <= s2_q;
            end
            panel_data_o <= show;
        end
    end
    assign panel_select_control = (ph_q == panel_pkg::PH_WRITE);
    assign panel_data_oe = (ph_q == panel_pkg::PH_WRITE);
    property p_share;
        @(posedge aclk) disable iff (!aresetn)
        (cnt_q == 8'(PHASE - 1)) |=> panel_select_control != $past(panel_select_control);
    endproperty
    a_share: assert property (p_share) else $error("select did not alternate");
endmodule

// file: hdl/panel_display.sv
// Front-panel option byte and error display with AXI4-Lite access.
`timescale 1ns/10ps
`include "panel_map.svh"
// How it works
// - No error: display mirrors the switches.
// - Switches 00 are shown as FF.
// - Error held until switch change; persistent reshown.
// - Errors except 06 sent to host.
// - Host input faults report codes 01 to 05.
// - Output aborted or unanswered shows code 06.
// - Enable faults report codes 10 to 13.
// - DMA faults report codes 20 to 23.
// - Status 31, timer bits 41, timer count 42.
// - Carrier 0C, DSR drop 0D, fill 0E.
// - Remote fill shows 0F, not an error.
// - Low option nibble: inhibits and terminator.
// - High option nibble: invert, test, modem, maintenance.
// - Switches DD show the option byte.
// - Aa presets low nibble, Bb high nibble.
// - CC shows pending nibbles as ba.
// - EE commits pending nibbles and shows them.
// - Select line alternates switch read and display.
module panel_display #(
    parameter int PHASE = 8
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave.
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Panel lines.
    input wire logic [7:0] panel_data_i,
    output logic [7:0] panel_data_o,
    output logic panel_data_oe,
    output logic panel_select_control,
    // Message to the host over the programmed-I/O channel.
    output logic [7:0] host_msg_data,
    output logic host_msg_valid,
    input wire logic host_msg_ready,
    // Option bits in force.
    output logic opt_inhibit_out,
    output logic opt_inhibit_in,
    output logic opt_terminator,
    output logic opt_invert_tx,
    output logic opt_self_test,
    output logic opt_no_modem,
    output logic opt_maintenance
);
    initial begin
        if (PHASE > 255) begin
            $error("PHASE too long");
        end
    end
    logic [7:0] sw;
    logic sw_valid;
    logic [7:0] prev_q;
    logic change;
    logic [7:0] err_q;
    logic persist_q;
    logic fill_q;
    logic [7:0] opt_q;
    logic [3:0] pend_lo_q;
    logic [3:0] pend_hi_q;
    logic [7:0] show_d;
    panel_pkg::err_msg_t msg_q;
    logic aw_q;
    logic w_q;
    logic [4:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_fire;
    logic raise;
    logic [7:0] raise_code;
    panel_mux #(
        .PHASE(PHASE)
    ) u_mux (
        .aclk(aclk),
        .aresetn(aresetn),
        .panel_data_i(panel_data_i),
        .panel_data_o(panel_data_o),
        .panel_data_oe(panel_data_oe),
        .panel_select_control(panel_select_control),
        .show(show_d),
        .sw(sw),
        .sw_valid(sw_valid)
    );
    // ****************************************************************
    // Switch change detection
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_q <= `SW_ZERO;
        end else if (sw_valid) begin
            prev_q <= sw;
        end
    end
    assign change = sw_valid && (sw != prev_q);
    // ****************************************************************
    // AXI4-Lite write channel
    // ****************************************************************
    // Error codes come from software that sees the faults a
    // write to the error register raises a code; bit 8 marks it persistent.
    assign s_axi_awready = !aw_q && !s_axi_bvalid;
    assign s_axi_wready = !w_q && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 5'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else if (wr_fire) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
        end
    end
    assign wr_fire = aw_q && w_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `AXI_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            case ({awaddr_q[4:2], 2'b00})
                `REG_CTRL, `REG_ERROR, `REG_OPTION: s_axi_bresp <= `AXI_OKAY;
                default: s_axi_bresp <= `AXI_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
    assign raise = wr_fire && {awaddr_q[4:2], 2'b00} == `REG_ERROR && wstrb_q[0]
        && wdata_q[7:0] != `ERR_NONE;
    assign raise_code = wdata_q[7:0];
    // ****************************************************************
    // Error hold and fill status
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fill_q <= 1'b0;
        end else if (wr_fire && {awaddr_q[4:2], 2'b00} == `REG_CTRL && wstrb_q[0]) begin
            fill_q <= wdata_q[0];
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            err_q <= `ERR_NONE;
            persist_q <= 1'b0;
        end else if (raise) begin
            err_q <= raise_code;
            persist_q <= wstrb_q[1] && wdata_q[8];
        end else begin
            if (wr_fire && {awaddr_q[4:2], 2'b00} == `REG_CTRL && wstrb_q[0] && wdata_q[1]) begin
                persist_q <= 1'b0;
            end
            if (change && !persist_q) begin
                err_q <= `ERR_NONE;
            end
        end
    end
    // ****************************************************************
    // Host message
    // ****************************************************************
    // One pending word only; a newer error replaces an unsent one.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            msg_q <= '0;
        end else if (raise && raise_code != `ERR_OUT_ABORT) begin
            msg_q.valid <= 1'b1;
            msg_q.code <= raise_code;
        end else if (host_msg_ready) begin
            msg_q.valid <= 1'b0;
        end
    end
    assign host_msg_valid = msg_q.valid;
    assign host_msg_data = msg_q.code;
    // ****************************************************************
    // Option byte
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_lo_q <= `NIB_RESET;
            pend_hi_q <= `NIB_RESET;
            opt_q <= `OPT_RESET;
        end else begin
            if (sw_valid && sw[7:4] == `SW_PRE_LO) begin
                pend_lo_q <= sw[3:0];
            end
            if (sw_valid && sw[7:4] == `SW_PRE_HI) begin
                pend_hi_q <= sw[3:0];
            end
            // A panel commit outranks a software write landing on the same edge.
            if (sw_valid && sw == `SW_ENTER) begin
                opt_q <= {pend_hi_q, pend_lo_q};
            end else if (wr_fire && {awaddr_q[4:2], 2'b00} == `REG_OPTION && wstrb_q[0]) begin
                opt_q <= wdata_q[7:0];
            end
        end
    end
    assign opt_inhibit_out = opt_q[`OPT_NO_OUT];
    assign opt_inhibit_in = opt_q[`OPT_NO_IN];
    assign opt_terminator = opt_q[`OPT_TERM];
    assign opt_invert_tx = opt_q[`OPT_INVERT];
    assign opt_self_test = opt_q[`OPT_SELFTEST];
    assign opt_no_modem = opt_q[`OPT_NO_MODEM];
    assign opt_maintenance = opt_q[`OPT_MAINT];
    // ****************************************************************
    // Display selection
    // ****************************************************************
    always_comb begin
        if (err_q != `ERR_NONE) begin
            show_d = err_q;
        end else if (fill_q) begin
            show_d = `ERR_FILLING;
        end else if (prev_q == `SW_SHOW_OPT || prev_q == `SW_ENTER) begin
            show_d = opt_q;
        end else if (prev_q == `SW_CHECK) begin
            show_d = {pend_hi_q, pend_lo_q};
        end else if (prev_q == `SW_ZERO) begin
            show_d = `DISP_IDLE;
        end else begin
            show_d = prev_q;
        end
    end
    // ****************************************************************
    // AXI4-Lite read channel
    // ****************************************************************
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `AXI_OKAY;
            case ({s_axi_araddr[4:2], 2'b00})
                `REG_CTRL: s_axi_rdata <= {31'h0, fill_q};
                `REG_ERROR: s_axi_rdata <= {23'h0, persist_q, err_q};
                `REG_STATUS: s_axi_rdata <= {23'h0, msg_q.valid, show_d};
                `REG_OPTION: s_axi_rdata <= {24'h0, opt_q};
                `REG_PANEL: s_axi_rdata <= {16'h0, pend_hi_q, pend_lo_q, prev_q};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `AXI_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_enter;
        sw_valid && sw == `SW_ENTER;
    endsequence
    property p_zero_ff;
        @(posedge aclk) disable iff (!aresetn)
        (err_q == `ERR_NONE && !fill_q && prev_q == `SW_ZERO) |-> show_d == `DISP_IDLE;
    endproperty
    a_zero_ff: assert property (p_zero_ff) else $error("zero not shown as FF");
    property p_mirror;
        @(posedge aclk) disable iff (!aresetn)
        (err_q == `ERR_NONE && !fill_q && prev_q != `SW_ZERO && prev_q != `SW_CHECK
            && prev_q != `SW_SHOW_OPT && prev_q != `SW_ENTER) |-> show_d == prev_q;
    endproperty
    a_mirror: assert property (p_mirror) else $error("switch not mirrored");
    property p_clear;
        @(posedge aclk) disable iff (!aresetn)
        (change && !persist_q && !raise) |=> err_q == `ERR_NONE;
    endproperty
    a_clear: assert property (p_clear) else $error("error not cleared on change");
    property p_no06;
        @(posedge aclk) disable iff (!aresetn)
        (raise && raise_code == `ERR_OUT_ABORT && !msg_q.valid) |=> !msg_q.valid;
    endproperty
    a_no06: assert property (p_no06) else $error("code 06 sent to host");
    property p_send;
        @(posedge aclk) disable iff (!aresetn)
        (raise && raise_code != `ERR_OUT_ABORT) |=> host_msg_valid && host_msg_data == $past(raise_code);
    endproperty
    a_send: assert property (p_send) else $error("error not sent to host");
    property p_enter;
        @(posedge aclk) disable iff (!aresetn)
        s_enter |=> opt_q == $past({pend_hi_q, pend_lo_q});
    endproperty
    a_enter: assert property (p_enter) else $error("option not committed");
    property p_check;
        @(posedge aclk) disable iff (!aresetn)
        (err_q == `ERR_NONE && !fill_q && prev_q == `SW_CHECK) |-> show_d == {pend_hi_q, pend_lo_q};
    endproperty
    a_check: assert property (p_check) else $error("pending nibbles not shown");
    property p_preset;
        @(posedge aclk) disable iff (!aresetn)
        (sw_valid && sw[7:4] == `SW_PRE_LO) |=> pend_lo_q == $past(sw[3:0]);
    endproperty
    a_preset: assert property (p_preset) else $error("low nibble not preset");
    property p_showopt;
        @(posedge aclk) disable iff (!aresetn)
        (err_q == `ERR_NONE && !fill_q && prev_q == `SW_SHOW_OPT) |-> show_d == opt_q;
    endproperty
    a_showopt: assert property (p_showopt) else $error("option byte not shown");
    property p_raise;
        @(posedge aclk) disable iff (!aresetn)
        raise |=> err_q == $past(raise_code);
    endproperty
    a_raise: assert property (p_raise) else $error("error code not raised");
    property p_hold;
        @(posedge aclk) disable iff (!aresetn)
        (change && persist_q && !raise) |=> err_q == $past(err_q);
    endproperty
    a_hold: assert property (p_hold) else $error("persistent error lost");
    property p_fill;
        @(posedge aclk) disable iff (!aresetn)
        (err_q == `ERR_NONE && fill_q) |-> show_d == `ERR_FILLING;
    endproperty
    a_fill: assert property (p_fill) else $error("fill status not shown");
    property p_optwrite;
        @(posedge aclk) disable iff (!aresetn)
        (wr_fire && {awaddr_q[4:2], 2'b00} == `REG_OPTION && wstrb_q[0]
            && !(sw_valid && sw == `SW_ENTER)) |=> opt_q == $past(wdata_q[7:0]);
    endproperty
    a_optwrite: assert property (p_optwrite) else $error("option write lost");
endmodule

// file: bench/panel_operator.sv
// Operator model: thumbwheel switches and the eye that reads the display.
`timescale 1ns/10ps
module panel_operator (
    // Clock.
    input wire logic aclk,
    // Panel lines from the device.
    input wire logic panel_select_control,
    input wire logic panel_data_oe,
    input wire logic [7:0] panel_data_o,
    // Operator side.
    input wire logic [7:0] setting,
    output logic [7:0] lines,
    output logic [7:0] seen
);
    // Switches reach the lines only in the read phase; in the write phase the lines carry the display data.
    assign lines = panel_data_oe ? panel_data_o : (panel_select_control ? ~setting : setting);
    initial seen = 8'h00;
    always @(posedge aclk) begin
        if (panel_select_control && panel_data_oe) begin
            seen <= panel_data_o;
        end
    end
endmodule

// file: bench/front_panel_option_error_display_bench.sv
// Self-checking bench for the front-panel option and error display.
`timescale 1ns/10ps
module front_panel_option_error_display_bench;
    // ****************************************************************
    // Signals
    // ****************************************************************
    localparam int PHASE = 4;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [4:0] awaddr = 5'h00;
    logic [4:0] araddr = 5'h00;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic host_msg_ready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, oe, sel, msg_valid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, rd;
    logic [7:0] disp_o, lines, seen, msg_data;
    logic [7:0] sw = 8'h00;
    logic o_out, o_in, o_term, o_inv, o_test, o_modem, o_maint;
    int mismatches = 0;
    int checked = 0;
    logic [7:0] codes [19] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h10, 8'h11, 8'h12, 8'h13,
        8'h20, 8'h21, 8'h22, 8'h23, 8'h31, 8'h41, 8'h42, 8'h0c, 8'h0d, 8'h0e};

    always #10 aclk = ~aclk;

    panel_display #(.PHASE(PHASE)) i_panel_display (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .panel_data_i(lines), .panel_data_o(disp_o), .panel_data_oe(oe),
        .panel_select_control(sel),
        .host_msg_data(msg_data), .host_msg_valid(msg_valid), .host_msg_ready(host_msg_ready),
        .opt_inhibit_out(o_out), .opt_inhibit_in(o_in), .opt_terminator(o_term),
        .opt_invert_tx(o_inv), .opt_self_test(o_test), .opt_no_modem(o_modem),
        .opt_maintenance(o_maint)
    );

    panel_operator i_panel_operator (
        .aclk(aclk), .panel_select_control(sel), .panel_data_oe(oe), .panel_data_o(disp_o),
        .setting(sw), .lines(lines), .seen(seen)
    );

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task check(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task results;
        if (mismatches == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Each channel is released at the rising edge at which its ready is seen high.
    task axi_write(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hf;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        check(32'(bresp), 32'(er));
        bready <= 1'b0;
    endtask

    task axi_read(input logic [4:0] a, output logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        check(32'(rresp), 32'(er));
        rready <= 1'b0;
    endtask

    task settle;
        repeat (8 * PHASE) @(posedge aclk);
    endtask

    task set_sw(input logic [7:0] v);
        @(posedge aclk);
        sw <= v;
        settle;
    endtask

    task take_msg(input logic [7:0] c);
        do @(negedge aclk); while (msg_valid !== 1'b1);
        check(32'(msg_data), 32'(c));
        @(posedge aclk);
        host_msg_ready <= 1'b1;
        @(posedge aclk);
        host_msg_ready <= 1'b0;
    endtask

    function automatic logic [31:0] opts();
        return {24'h0, o_maint, o_modem, o_test, o_inv, 1'b0, o_term, o_in, o_out};
    endfunction

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(5'h0c, rd, 2'b00);
        check(rd & 32'hff, 32'h0);
        check(opts(), 32'h0);
        set_sw(8'h00);
        check(32'(seen), 32'hff);
        set_sw(8'h5a);
        check(32'(seen), 32'h5a);
        set_sw(8'hff);
        for (int i = 0; i < 19; i++) begin
            axi_write(5'h04, {24'h0, codes[i]}, 2'b00);
            take_msg(codes[i]);
            settle;
            check(32'(seen), 32'(codes[i]));
            set_sw(~sw);
            check(32'(seen), 32'hff);
        end
        axi_write(5'h04, 32'h06, 2'b00);
        settle;
        check(32'(msg_valid), 32'h0);
        check(32'(seen), 32'h06);
        set_sw(~sw);
        // A persistent code must survive a switch change until it is cleared.
        axi_write(5'h04, 32'h142, 2'b00);
        take_msg(8'h42);
        axi_read(5'h04, rd, 2'b00);
        check(rd & 32'h1ff, 32'h142);
        set_sw(~sw);
        check(32'(seen), 32'h42);
        axi_read(5'h08, rd, 2'b00);
        check(rd & 32'hff, 32'h42);
        axi_write(5'h00, 32'h2, 2'b00);
        set_sw(~sw);
        check(32'(seen), 32'hff);
        axi_write(5'h00, 32'h1, 2'b00);
        settle;
        check(32'(seen), 32'h0f);
        axi_write(5'h00, 32'h0, 2'b00);
        settle;
        check(32'(seen), 32'hff);
        set_sw(8'ha5);
        set_sw(8'hb3);
        set_sw(8'hcc);
        check(32'(seen), 32'h35);
        axi_read(5'h10, rd, 2'b00);
        check(rd & 32'hffff, 32'h35cc);
        set_sw(8'hdd);
        check(32'(seen), 32'h00);
        set_sw(8'hee);
        check(32'(seen), 32'h35);
        check(opts(), 32'h35);
        axi_read(5'h0c, rd, 2'b00);
        check(rd & 32'hff, 32'h35);
        set_sw(8'hff);
        axi_write(5'h0c, 32'hca, 2'b00);
        set_sw(8'hdd);
        check(32'(seen), 32'hca);
        check(opts(), 32'hc2);
        set_sw(8'h00);
        check(32'(seen), 32'hff);
        axi_write(5'h14, 32'h0, 2'b10);
        axi_read(5'h14, rd, 2'b10);
        results;
    end

    // The sequence needs about 2000 cycles; this limit leaves ample margin.
    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        results;
    end
endmodule
